// ---- logic/eipd_cfg.svh ----
// register map, field positions and reset values of the pin event detector
`ifndef EIPD_CFG_SVH
`define EIPD_CFG_SVH

`define EIPD_CSR_ADDR   12'h000
`define EIPD_BIT_MODE   3'h0
`define EIPD_BIT_INTEN  3'h1
`define EIPD_BIT_ACK    3'h2
`define EIPD_BIT_FLAG   3'h3
`define EIPD_BIT_PINEN  3'h4
`define EIPD_BIT_POL    3'h5
`define EIPD_CTRL_RST   1'h0
`define EIPD_FLAG_RST   1'h0
`define EIPD_RDATA_RST  32'h0000_0000

`endif

// ---- logic/eipd_pkg.sv ----
// types shared by the pin event detector modules
package eipd_pkg;

  // state of the register and detection core
  typedef struct packed {
    logic        pin_en;
    logic        pol;
    logic        int_en;
    logic        mode;
    logic        flag;
    logic [31:0] rdata;
  } eipd_core_s;

  // state of the pin synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } eipd_sync_s;

endpackage

// ---- logic/eipd_pin_if.sv ----
// synchronised pin samples passed from synchroniser to core
`timescale 1ns/1ps
interface eipd_pin_if;
  logic level;
  logic prev;

  modport sync_side (output level, output prev);
  modport core_side (input level, input prev);
endinterface

// ---- logic/eipd_pin_sync.sv ----
// two-stage pin synchroniser with one extra sample for edge detection
`timescale 1ns/1ps
`include "eipd_cfg.svh"
module eipd_pin_sync
  import eipd_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pin_raw,
  eipd_pin_if.sync_side   pin
);

  eipd_sync_s st;
  eipd_sync_s next_st;

  // two-stage synchroniser
  // s1 feeds only s2; prev is one sample older than s2
  always_comb begin
    next_st      = st;
    next_st.s1   = pin_raw;
    next_st.s2   = st.s1;
    next_st.prev = st.s2;
  end

  // idle pin level is unknown, so reset to zero and let detection ignore startup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin.level = st.s2;
  assign pin.prev  = st.prev;

  a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, 3) |-> st.s2 == $past(pin_raw, 2))
    else $error("pin level is not the input delayed by two cycles");

endmodule

// ---- logic/eipd_top.sv ----
// external request pin detector with its APB control and status register
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "eipd_cfg.svh"
module eipd_top
  import eipd_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              pin_raw,
  output logic                   pull_up_en,
  output logic                   pull_down_en,
  output logic                   irq_req
);

  // the register sits in the low word; anything narrower cannot decode it
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 4 and 32");
  end

  // decoding shared by the write path, the read path and the error reply

  // true when the byte address selects the control and status word
  function automatic logic csr_hit(input logic [ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'h0000_0000;
    wide[ADDR_W-1:0] = addr;
    return wide == 32'(`EIPD_CSR_ADDR);
  endfunction

  // state

  eipd_core_s st;
  eipd_core_s next_st;

  eipd_pin_if pin ();

  eipd_pin_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_raw (pin_raw),
    .pin     (pin.sync_side)
  );

  // bus phase decode

  logic setup_ph;
  logic access_ph;
  logic wr_csr;
  logic ack_wr;

  // the slave answers at once, so every access phase is its last
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  // only byte lane 0 carries the six implemented bits
  assign wr_csr    = access_ph && pwrite && csr_hit(paddr) && pstrb[0];
  // zero in the acknowledge bit is no acknowledge
  assign ack_wr    = wr_csr && pwdata[`EIPD_BIT_ACK];

  // pin event detection

  logic asserted;
  logic edge_seen;
  logic pin_event;
  logic level_hold;

  // polarity selects sense
  // low level counts as asserted when the falling sense is chosen
  assign asserted  = st.pol ? pin.level : !pin.level;
  // an edge is a change between successive samples toward the asserted sense
  assign edge_seen = asserted && (pin.level != pin.prev);
  assign pin_event = st.pin_en && (edge_seen || (st.mode && asserted));
  assign level_hold = st.pin_en && st.mode && asserted;

  // register image as software sees it

  logic [31:0] csr_image;

  always_comb begin
    csr_image                  = 32'h0000_0000;
    csr_image[`EIPD_BIT_MODE]  = st.mode;
    csr_image[`EIPD_BIT_INTEN] = st.int_en;
    csr_image[`EIPD_BIT_FLAG]  = st.flag;
    csr_image[`EIPD_BIT_PINEN] = st.pin_en;
    csr_image[`EIPD_BIT_POL]   = st.pol;
  end

  // next state

  always_comb begin
    next_st = st;

    // four read/write controls, written as a whole byte
    if (wr_csr) begin
      next_st.mode   = pwdata[`EIPD_BIT_MODE];
      next_st.int_en = pwdata[`EIPD_BIT_INTEN];
      next_st.pin_en = pwdata[`EIPD_BIT_PINEN];
      next_st.pol    = pwdata[`EIPD_BIT_POL];
    end

    // acknowledge clears flag
    // set is applied last so an event in the clearing cycle survives
    if (ack_wr && !level_hold) begin
      next_st.flag = 1'h0;
    end
    if (pin_event) begin
      next_st.flag = 1'h1;
    end

    // read data is captured in the setup cycle so prdata comes from a flop;
    // a flag change in the single cycle between capture and answer shows next read
    if (setup_ph && !pwrite) begin
      next_st.rdata = csr_hit(paddr) ? csr_image : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.pin_en <= `EIPD_CTRL_RST;
      st.pol    <= `EIPD_CTRL_RST;
      st.int_en <= `EIPD_CTRL_RST;
      st.mode   <= `EIPD_CTRL_RST;
      st.flag   <= `EIPD_FLAG_RST;
      st.rdata  <= `EIPD_RDATA_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs

  // zero wait states: the access phase always completes in one cycle
  assign pready  = 1'h1;
  // unmapped addresses get an error reply, reads of them return zero
  assign pslverr = access_ph && !csr_hit(paddr);
  assign prdata  = st.rdata;

  // pull resistor select
  // pull opposite to the asserted sense so a floating pin stays idle
  assign pull_up_en   = st.pin_en && !st.pol;
  assign pull_down_en = st.pin_en && st.pol;

  assign irq_req = st.flag && st.int_en;

  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_disabled_quiet: assert property (
    !st.pin_en && !st.flag |=> !st.flag)
    else $error("flag set while pin function disabled");

  a_pull_select: assert property (
    st.pin_en |-> (pull_up_en != pull_down_en) && (pull_down_en == st.pol))
    else $error("wrong pull resistor for polarity");

  a_falling_edge: assert property (
    st.pin_en && !st.pol && pin.prev && !pin.level |=> st.flag)
    else $error("falling edge missed");

  a_edge_only: assert property (
    st.pin_en && !st.mode && !st.flag && pin.level == pin.prev
    && !(wr_csr && pwdata[`EIPD_BIT_PINEN]) |=> !st.flag)
    else $error("steady pin set flag in edge mode");

  a_flag_read: assert property (
    setup_ph && !pwrite && csr_hit(paddr) |=> prdata[`EIPD_BIT_FLAG] == $past(st.flag))
    else $error("flag not visible at its bit");

  a_ack_clear: assert property (
    ack_wr && !level_hold && !pin_event |=> !st.flag)
    else $error("acknowledge failed to clear flag");

  a_ack_zero: assert property (
    wr_csr && !pwdata[`EIPD_BIT_ACK] && st.flag |=> st.flag)
    else $error("writing zero to acknowledge changed flag");

  a_level_hold: assert property (
    ack_wr && level_hold |=> st.flag)
    else $error("flag cleared while level held");

  a_irq_follow: assert property (
    $rose(st.flag) && st.int_en |-> irq_req ##1 (irq_req == (st.flag && st.int_en)))
    else $error("interrupt request does not follow flag");

  a_reserved_zero: assert property (
    access_ph && !pwrite |-> prdata[7:6] == 2'h0 && !prdata[`EIPD_BIT_ACK])
    else $error("reserved or acknowledge bit read non-zero");

  a_reset_quiet: assert property (
    $rose(presetn) |-> !irq_req && !pull_up_en && !pull_down_en && !st.flag)
    else $error("block not quiet after reset");

  a_rising_edge: assert property (
    st.pin_en && st.pol && !pin.prev && pin.level |=> st.flag)
    else $error("rising edge missed");

  a_wrong_edge: assert property (
    st.pin_en && !st.mode && !st.pol && !st.flag && !pin.prev && pin.level |=> !st.flag)
    else $error("rising edge set flag under falling polarity");

  a_low_level: assert property (
    st.pin_en && st.mode && !st.pol && !pin.level |=> st.flag)
    else $error("held low level missed in level mode");

  a_high_level: assert property (
    st.pin_en && st.mode && st.pol && pin.level |=> st.flag)
    else $error("held high level missed in level mode");

  a_no_event_off: assert property (
    !st.pin_en |-> !pin_event)
    else $error("event seen while pin function disabled");

  a_disabled_keep: assert property (
    !st.pin_en && st.flag && !ack_wr |=> st.flag)
    else $error("pending flag lost while pin function disabled");

  a_pull_off: assert property (
    !st.pin_en |-> !pull_up_en && !pull_down_en)
    else $error("pull resistor on while pin function disabled");

  a_pull_up_fall: assert property (
    st.pin_en && !st.pol |-> pull_up_en && !pull_down_en)
    else $error("falling sense without pull-up");

  a_flag_cause: assert property (
    $rose(st.flag) |-> $past(pin_event))
    else $error("flag set without a pin event");

  a_flag_stays: assert property (
    st.flag && !ack_wr |=> st.flag)
    else $error("flag cleared without acknowledge");

  a_ack_read_zero: assert property (
    setup_ph && !pwrite |=> !prdata[`EIPD_BIT_ACK])
    else $error("acknowledge bit read as one");

  a_level_rearm: assert property (
    level_hold |=> st.flag)
    else $error("flag clear while asserted level held");

  a_irq_masked: assert property (
    !st.int_en |-> !irq_req)
    else $error("request raised while interrupt disabled");

  a_irq_flag: assert property (
    st.flag && st.int_en |-> irq_req)
    else $error("request missing for enabled flag");

  a_irq_no_flag: assert property (
    !st.flag |-> !irq_req)
    else $error("request raised without flag");

  a_write_pin_ctrl: assert property (
    wr_csr |=> st.pin_en == $past(pwdata[`EIPD_BIT_PINEN])
    && st.pol == $past(pwdata[`EIPD_BIT_POL]))
    else $error("pin controls not taken from write");

  a_write_mode_ctrl: assert property (
    wr_csr |=> st.mode == $past(pwdata[`EIPD_BIT_MODE])
    && st.int_en == $past(pwdata[`EIPD_BIT_INTEN]))
    else $error("mode controls not taken from write");

  a_ctrl_keep: assert property (
    !wr_csr |=> $stable({st.pin_en, st.pol, st.mode, st.int_en}))
    else $error("controls changed without a write");

  a_read_pin_ctrl: assert property (
    setup_ph && !pwrite && csr_hit(paddr) |=> prdata[`EIPD_BIT_PINEN] == $past(st.pin_en)
    && prdata[`EIPD_BIT_POL] == $past(st.pol))
    else $error("pin controls not visible on read");

  a_read_mode_ctrl: assert property (
    setup_ph && !pwrite && csr_hit(paddr) |=> prdata[`EIPD_BIT_MODE] == $past(st.mode)
    && prdata[`EIPD_BIT_INTEN] == $past(st.int_en))
    else $error("mode controls not visible on read");

  a_upper_zero: assert property (
    prdata[31:8] == 24'h00_0000)
    else $error("bits above the register read non-zero");

  a_unmapped_zero: assert property (
    setup_ph && !pwrite && !csr_hit(paddr) |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  a_prev_follows: assert property (
    pin.prev == $past(pin.level))
    else $error("edge history is not the previous sample");

  a_reset_ctrl: assert property (
    $rose(presetn) |-> !st.pin_en && !st.pol && !st.int_en && !st.mode)
    else $error("controls not cleared by reset");

  // scenarios worth seeing
  c_edge_event: cover property (st.pin_en && !st.mode && pin_event ##1 irq_req);
  c_level_held: cover property (ack_wr && level_hold ##1 st.flag);
  c_ack_clear:  cover property (st.flag ##1 ack_wr ##1 !st.flag);
  c_bad_addr:   cover property (pslverr);
  c_rise_event: cover property (st.pol && pin_event);

endmodule

// ---- test/eipd_pin_src.sv ----
// model of the external request pin source, with the pad's pull resistors
`timescale 1ns/1ps
module eipd_pin_src (
  input  wire logic pclk,
  input  wire logic drive_en,
  input  wire logic drive_val,
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  output logic      pin_raw
);
  logic toggle = 1'h0;

  // a floating, unpulled pin wanders so it never passes for a steady level
  always @(posedge pclk) begin
    toggle <= ~toggle;
  end

  assign pin_raw = drive_en ? drive_val : pull_up_en ? 1'h1 : pull_down_en ? 1'h0 : toggle;
endmodule

// ---- test/external_int_pin_detector_tb_top.sv ----
// self-checking bench for the pin event detector
`timescale 1ns/1ps
module external_int_pin_detector_tb_top;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_raw;
  logic        pull_up_en;
  logic        pull_down_en;
  logic        irq_req;
  logic        drv_en = 1'h1;
  logic        drv_val = 1'h0;
  logic [32:0] exp_q[$];
  int          mismatches = 0;
  int          checks = 0;
  int          seed = 40175;

  always #10 pclk = ~pclk;

  eipd_top #(.ADDR_W(12)) u_eipd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_raw(pin_raw), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .irq_req(irq_req));

  eipd_pin_src u_eipd_pin_src (.pclk(pclk), .drive_en(drv_en), .drive_val(drv_val),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .pin_raw(pin_raw));

  task automatic chk(string what, logic [32:0] seen, logic [32:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask

  // one apb transfer; every transfer leaves its expected {error, data}, writes with zero data
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [32:0] want);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(want);
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  // upper data bits are random: only the low byte may matter
  task automatic wr(logic [7:0] v);
    logic [31:0] r;
    r = $random(seed);
    apb(1'h1, 12'h000, {r[31:8], v}, 33'h0);
  endtask

  task automatic rd(logic [7:0] v);
    apb(1'h0, 12'h000, 32'h0, {25'h0, v});
  endtask

  // watcher: each completed transfer takes the oldest note; a write is judged by its error reply
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (exp_q.size() == 0) chk("unexpected transfer", 33'h0, 33'h1);
      else chk(pwrite ? "write" : "read", {pslverr, pwrite ? 32'h0000_0000 : prdata},
               exp_q.pop_front());
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    rd(8'h00);
    chk("irq", irq_req, 1'h0);
    wr(8'hFF);
    rd(8'h33);
    chk("pulls", {pull_up_en, pull_down_en}, 2'h1);
    $display("test register bits done");
    // m[0] is the mode bit, m[1] the polarity; pin starts deasserted
    for (int m = 0; m < 4; m++) begin
      // park the pin function first: moving the pin under the old sense leaves a held event
      wr(8'h00);
      drv_val <= ~m[1];
      repeat (4) @(posedge pclk);
      wr({2'h0, m[1], 3'h5, 1'h1, m[0]});
      rd({2'h0, m[1], 3'h4, 1'h1, m[0]});
      chk("pulls", {pull_up_en, pull_down_en}, {~m[1], m[1]});
      drv_val <= m[1];
      repeat (5) @(posedge pclk);
      chk("irq", irq_req, 1'h1);
      rd({2'h0, m[1], 3'h6, 1'h1, m[0]});
      wr({2'h0, m[1], 3'h5, 1'h1, m[0]});
      rd({2'h0, m[1], 1'h1, m[0], 1'h0, 1'h1, m[0]});
      drv_val <= ~m[1];
      repeat (5) @(posedge pclk);
      wr({2'h0, m[1], 3'h4, 1'h1, m[0]});
      rd({2'h0, m[1], 1'h1, m[0], 1'h0, 1'h1, m[0]});
      wr({2'h0, m[1], 3'h5, 1'h1, m[0]});
      rd({2'h0, m[1], 3'h4, 1'h1, m[0]});
    end
    $display("test polarity and mode done");
    // pin now held low, the asserted level for falling polarity
    wr(8'h07);
    repeat (5) @(posedge pclk);
    rd(8'h03);
    chk("irq", irq_req, 1'h0);
    wr(8'h16);
    repeat (5) @(posedge pclk);
    rd(8'h12);
    wr(8'h11);
    repeat (5) @(posedge pclk);
    rd(8'h19);
    chk("irq", irq_req, 1'h0);
    $display("test enables done");
    r = $random(seed);
    apb(1'h1, {r[11:3], 3'h4}, 32'h0000_0000, {1'h1, 32'h0});
    apb(1'h0, {r[11:3], 3'h4}, 32'h0000_0000, {1'h1, 32'h0});
    rd(8'h19);
    $display("test unmapped done");
    // byte lane 0 off: the write must not reach the register
    pstrb <= 4'hE;
    wr(8'h00);
    pstrb <= 4'hF;
    rd(8'h19);
    // released pin rests at the pull-up level, so the held event can now be acknowledged
    drv_en <= 1'h0;
    repeat (5) @(posedge pclk);
    wr(8'h15);
    rd(8'h11);
    drv_en <= 1'h1;
    $display("test strobe and pull done");
    // reset in mid-run returns the block to its quiet state
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    rd(8'h00);
    chk("pulls", {pull_up_en, pull_down_en}, 2'h0);
    chk("irq", irq_req, 1'h0);
    $display("test reset done");
    repeat (3) @(posedge pclk);
    wrap_up();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end
endmodule
